// ===== lgr_params.svh
`ifndef LGR_PARAMS_SVH
`define LGR_PARAMS_SVH

// Register numbers seen by the master, as data addresses.
`define LGR_REG_GROSS_PROD_HI 16'h0000
`define LGR_REG_GROSS_PROD_LO 16'h0001
`define LGR_REG_GROSS_INTF_HI 16'h0002
`define LGR_REG_GROSS_INTF_LO 16'h0003
`define LGR_REG_GROSS_TOT_HI 16'h0004
`define LGR_REG_GROSS_TOT_LO 16'h0005
`define LGR_REG_ULLAGE_HI 16'h0006
`define LGR_REG_ULLAGE_LO 16'h0007
`define LGR_REG_NET_PROD_HI 16'h0008
`define LGR_REG_NET_PROD_LO 16'h0009
`define LGR_REG_ALARM_HI 16'h000A
`define LGR_REG_ALARM_LO 16'h000B
`define LGR_REG_VCF_ERR 16'h000C
`define LGR_REG_VOL_ERR 16'h000D
`define LGR_REG_CFG_ERR 16'h000E
// Data address of register 35198, the first one outside the map.
`define LGR_MAP_END 16'h144D

// Reserved answers and exception code.
`define LGR_RSV_WORD 16'h8000
`define LGR_EXC_ADDR 8'h02

// Alarm/status bit positions (bit 0 is the first documented bit).
`define LGR_BIT_INTF_HI 0
`define LGR_BIT_INTF_LO 1
`define LGR_BIT_PROD_HI 2
`define LGR_BIT_PROD_LO 3
`define LGR_BIT_LIM_HI 4
`define LGR_BIT_LIM_LO 5
`define LGR_BIT_TAVG_HI 6
`define LGR_BIT_TAVG_LO 7
`define LGR_BIT_MAGNET 8
`define LGR_BIT_TSENS0 9
`define LGR_BIT_TAVG_ERR 14

// Configuration limits.
`define LGR_TEC_MIN 32'h0000_0A8C
`define LGR_TEC_MAX 32'h0000_2454
`define LGR_ADDR_MIN 8'h01
`define LGR_ADDR_MAX 8'hF7
`define LGR_AVG_MAX 8'h3C
`define LGR_AVG_STEP 8'h05
`define LGR_DENS_MAX 4'h8
`define LGR_VOLU_MAX 4'h6
`define LGR_LENU_MAX 4'h6
`define LGR_MASSU_MAX 4'h5

// Configuration error bits in the own configuration status word.
`define LGR_CERR_METHOD 0
`define LGR_CERR_TEC 1
`define LGR_CERR_AVG 2
`define LGR_CERR_TUNIT 3
`define LGR_CERR_DUNIT 4
`define LGR_CERR_VUNIT 5
`define LGR_CERR_LUNIT 6
`define LGR_CERR_MUNIT 7
`define LGR_CERR_ADDR 8
`define LGR_CERR_ALMU 9

// Fixed-point divisor applied after the correction-factor product (x10000).
`define LGR_VCF_SCALE 32'h0000_2710

`endif

// ===== lgr_pkg.sv
package lgr_pkg;

  // Temperature correction methods.
  typedef enum logic [2:0] {
    LGR_METH_NONE = 3'h0,
    LGR_METH_HEAVY_OIL = 3'h1,
    LGR_METH_LIGHT_OIL = 3'h2,
    LGR_METH_CHEMICAL = 3'h3,
    LGR_METH_WIDE_CHEMICAL = 3'h4,
    LGR_METH_CUSTOM = 3'h5
  } lgr_method_t;

  typedef enum logic [1:0] {
    LGR_ALMU_VOLUME = 2'h2,
    LGR_ALMU_LENGTH = 2'h3
  } lgr_almu_t;

  // Read answer sequencing.
  typedef enum {
    LGR_ST_IDLE,
    LGR_ST_ANSWER
  } lgr_state_t;

endpackage

// ===== lgr_alarm_cmp.sv
`include "lgr_params.svh"

// One threshold pair: high when value >= hi limit, low when value <= lo.
module lgr_alarm_cmp (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic signed [31:0] value_i,
  input wire logic signed [31:0] hi_lim_i,
  input wire logic signed [31:0] lo_lim_i,
  input wire logic enable_i,
  output logic high_o,
  output logic low_o
);

  typedef struct packed {
    logic high;
    logic low;
  } lgr_cmp_state_t;

  lgr_cmp_state_t state_ff;
  lgr_cmp_state_t nxt_state;

  // Comparisons are inclusive at both limits.
  always_comb begin
    nxt_state.high = enable_i && (value_i >= hi_lim_i);
    nxt_state.low = enable_i && (value_i <= lo_lim_i);
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign high_o = state_ff.high;
  assign low_o = state_ff.low;

endmodule

// ===== lgr_level_gauge_regs.sv
`include "lgr_params.svh"

// What this block does
// - 32-bit values sit in a high register then a low register.
// - Fractional quantities are sent pre-multiplied by their scale factor.
// - Correction method accepts codes 1 to 5 only.
// - Under the chemical method (3), expansion coefficient accepted only from 270.0 to 930.0.
// - Averaging code 0 means one second; 5 to 60 in fives.
// - Status bits 1-8 are interface, product, limit, temperature alarms.
// - Bit 9 magnet missing, 10-14 sensor errors, 15 average error.
// - Status bits read 1 while active; bits 16 to 32 read 0.
// - Correction-factor error reads 0 on success else code 1 to 9.
// - Volume error reads 0 on success else code 1 to 4.
// - Reserved address inside the map reads 8000H at an even register, 0000H at an odd one.
// - Reads at register 35198 and above answer exception code 02.
// - Temperature units: 0 Celsius, 1 Fahrenheit.
// - Density units take codes 0 to 8.
// - Volume and length units take codes 0 to 6.
// - Mass units take codes 0 to 5.
// - Device address accepted only from 1 to 247.
// - Alarm unit type 2 volume, 3 length; limits use length only.
// - High alarm at value >= threshold, low alarm at <= threshold.
// - Gross product is total minus interface with two floats, else the total; ullage capacity minus total.
// - Net product volume is gross product times correction factor.
// - Every register is read-only, by function 03 or 04.
// - Returned values are in the unit selected for their type.
module lgr_level_gauge_regs (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Register read request from the framing logic.
  input wire logic rd_req_i,
  input wire logic [7:0] rd_func_i,
  input wire logic [15:0] rd_addr_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic rd_exc_o,
  output logic [7:0] rd_exc_code_o,
  // Settings, held by the configuration store.
  input wire logic [2:0] cfg_method_i,
  input wire logic [31:0] cfg_tec_i,
  input wire logic cfg_vol_mode_i,
  input wire logic [7:0] cfg_avg_code_i,
  input wire logic [3:0] cfg_temp_unit_i,
  input wire logic [3:0] cfg_dens_unit_i,
  input wire logic [3:0] cfg_vol_unit_i,
  input wire logic [3:0] cfg_len_unit_i,
  input wire logic [3:0] cfg_mass_unit_i,
  input wire logic [7:0] cfg_dev_addr_i,
  input wire logic [1:0] cfg_alarm_unit_i,
  input wire logic two_float_i,
  // Measurements, already scaled and in the selected unit.
  input wire logic signed [31:0] intf_meas_i,
  input wire logic signed [31:0] prod_meas_i,
  input wire logic signed [31:0] limit_meas_i,
  input wire logic signed [31:0] tavg_meas_i,
  input wire logic signed [31:0] intf_hi_lim_i,
  input wire logic signed [31:0] intf_lo_lim_i,
  input wire logic signed [31:0] prod_hi_lim_i,
  input wire logic signed [31:0] prod_lo_lim_i,
  input wire logic signed [31:0] limit_hi_lim_i,
  input wire logic signed [31:0] limit_lo_lim_i,
  input wire logic signed [31:0] tavg_hi_lim_i,
  input wire logic signed [31:0] tavg_lo_lim_i,
  input wire logic magnet_missing_i,
  input wire logic [4:0] tsens_err_i,
  input wire logic tavg_err_i,
  input wire logic [3:0] vcf_err_i,
  input wire logic [2:0] vol_err_i,
  input wire logic [31:0] gross_total_volume_i,
  input wire logic [31:0] gross_interface_volume_i,
  input wire logic [31:0] working_capacity_i,
  input wire logic [31:0] volume_correction_factor_i,
  // Decoded settings for the measurement logic.
  output logic strap_table_sel_o,
  output logic [5:0] avg_seconds_o,
  output logic [9:0] cfg_err_o,
  output logic [31:0] alarm_status_word_o
);

  typedef struct packed {
    lgr_pkg::lgr_state_t st;
    logic rd_valid;
    logic [15:0] rd_data;
    logic rd_exc;
    logic [7:0] rd_exc_code;
    logic strap_sel;
    logic [5:0] avg_sec;
    logic [9:0] cfg_err;
    logic [31:0] alarm_word;
    logic [31:0] gross_prod;
    logic [31:0] ullage;
    logic [31:0] net_prod;
  } lgr_top_state_t;

  lgr_top_state_t state_ff;
  lgr_top_state_t nxt_state;

  logic [7:0] alm_bits;
  logic len_alarms_ok;
  logic vol_ok;
  logic [63:0] net_wide;

  // Limit alarms are compared only in length units; others in either type.
  assign len_alarms_ok = (cfg_alarm_unit_i == 2'(lgr_pkg::LGR_ALMU_LENGTH));
  assign vol_ok = len_alarms_ok ||
    (cfg_alarm_unit_i == 2'(lgr_pkg::LGR_ALMU_VOLUME));

  lgr_alarm_cmp u_cmp_intf (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .value_i(intf_meas_i),
    .hi_lim_i(intf_hi_lim_i),
    .lo_lim_i(intf_lo_lim_i),
    .enable_i(vol_ok),
    .high_o(alm_bits[`LGR_BIT_INTF_HI]),
    .low_o(alm_bits[`LGR_BIT_INTF_LO])
  );

  lgr_alarm_cmp u_cmp_prod (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .value_i(prod_meas_i),
    .hi_lim_i(prod_hi_lim_i),
    .lo_lim_i(prod_lo_lim_i),
    .enable_i(vol_ok),
    .high_o(alm_bits[`LGR_BIT_PROD_HI]),
    .low_o(alm_bits[`LGR_BIT_PROD_LO])
  );

  lgr_alarm_cmp u_cmp_limit (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .value_i(limit_meas_i),
    .hi_lim_i(limit_hi_lim_i),
    .lo_lim_i(limit_lo_lim_i),
    .enable_i(len_alarms_ok),
    .high_o(alm_bits[`LGR_BIT_LIM_HI]),
    .low_o(alm_bits[`LGR_BIT_LIM_LO])
  );

  // Temperature alarms do not depend on the alarm unit type.
  lgr_alarm_cmp u_cmp_tavg (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .value_i(tavg_meas_i),
    .hi_lim_i(tavg_hi_lim_i),
    .lo_lim_i(tavg_lo_lim_i),
    .enable_i(1'b1),
    .high_o(alm_bits[`LGR_BIT_TAVG_HI]),
    .low_o(alm_bits[`LGR_BIT_TAVG_LO])
  );

  // The scaled factor is divided back out so the net value keeps its scale.
  assign net_wide = (state_ff.gross_prod * volume_correction_factor_i) /
    64'(`LGR_VCF_SCALE);

  // Decode settings, build the status word and answer read requests.
  always_comb begin
    logic [31:0] pair;
    logic in_pair;
    logic lo_half;
    pair = '0;
    in_pair = 1'b1;
    lo_half = rd_addr_i[0];
    nxt_state = state_ff;

    // Settings checks; a set bit marks a value outside its allowed codes.
    nxt_state.cfg_err = '0;
    nxt_state.cfg_err[`LGR_CERR_METHOD] =
      (cfg_method_i < 3'(lgr_pkg::LGR_METH_HEAVY_OIL)) ||
      (cfg_method_i > 3'(lgr_pkg::LGR_METH_CUSTOM));
    nxt_state.cfg_err[`LGR_CERR_TEC] =
      (cfg_method_i == 3'(lgr_pkg::LGR_METH_CHEMICAL)) &&
      ((cfg_tec_i < `LGR_TEC_MIN) || (cfg_tec_i > `LGR_TEC_MAX));
    nxt_state.cfg_err[`LGR_CERR_AVG] = (cfg_avg_code_i > `LGR_AVG_MAX) ||
      ((cfg_avg_code_i % `LGR_AVG_STEP) != 8'h00);
    nxt_state.cfg_err[`LGR_CERR_TUNIT] = (cfg_temp_unit_i > 4'h1);
    nxt_state.cfg_err[`LGR_CERR_DUNIT] =
      (cfg_dens_unit_i > `LGR_DENS_MAX);
    nxt_state.cfg_err[`LGR_CERR_VUNIT] =
      (cfg_vol_unit_i > `LGR_VOLU_MAX);
    nxt_state.cfg_err[`LGR_CERR_LUNIT] =
      (cfg_len_unit_i > `LGR_LENU_MAX);
    nxt_state.cfg_err[`LGR_CERR_MUNIT] =
      (cfg_mass_unit_i > `LGR_MASSU_MAX);
    nxt_state.cfg_err[`LGR_CERR_ADDR] = (cfg_dev_addr_i < `LGR_ADDR_MIN) ||
      (cfg_dev_addr_i > `LGR_ADDR_MAX);
    nxt_state.cfg_err[`LGR_CERR_ALMU] = !vol_ok;

    nxt_state.strap_sel = cfg_vol_mode_i;
    // An illegal averaging code falls back to the one-second default.
    if ((cfg_avg_code_i == 8'h00) || nxt_state.cfg_err[`LGR_CERR_AVG]) begin
      nxt_state.avg_sec = 6'h01;
    end else begin
      nxt_state.avg_sec = cfg_avg_code_i[5:0];
    end

    // Status word: upper bits stay zero for good.
    nxt_state.alarm_word = '0;
    nxt_state.alarm_word[7:0] = alm_bits;
    nxt_state.alarm_word[`LGR_BIT_MAGNET] = magnet_missing_i;
    nxt_state.alarm_word[`LGR_BIT_TSENS0 +: 5] = tsens_err_i;
    nxt_state.alarm_word[`LGR_BIT_TAVG_ERR] = tavg_err_i;

    // Volume relations; one float leaves the total as the product.
    nxt_state.gross_prod = two_float_i ?
      (gross_total_volume_i - gross_interface_volume_i) :
      gross_total_volume_i;
    nxt_state.ullage = working_capacity_i - gross_total_volume_i;
    nxt_state.net_prod = net_wide[31:0];

    // Answers last one cycle; the framing logic owns the reply.
    nxt_state.rd_valid = 1'b0;
    nxt_state.rd_exc = 1'b0;
    nxt_state.rd_exc_code = '0;
    case (state_ff.st)
      lgr_pkg::LGR_ST_IDLE: begin
        if (rd_req_i) begin
          nxt_state.st = lgr_pkg::LGR_ST_ANSWER;
          nxt_state.rd_valid = 1'b1;
          case (rd_addr_i)
            `LGR_REG_GROSS_PROD_HI, `LGR_REG_GROSS_PROD_LO:
              pair = state_ff.gross_prod;
            `LGR_REG_GROSS_INTF_HI, `LGR_REG_GROSS_INTF_LO:
              pair = gross_interface_volume_i;
            `LGR_REG_GROSS_TOT_HI, `LGR_REG_GROSS_TOT_LO:
              pair = gross_total_volume_i;
            `LGR_REG_ULLAGE_HI, `LGR_REG_ULLAGE_LO:
              pair = state_ff.ullage;
            `LGR_REG_NET_PROD_HI, `LGR_REG_NET_PROD_LO:
              pair = state_ff.net_prod;
            `LGR_REG_ALARM_HI, `LGR_REG_ALARM_LO:
              pair = state_ff.alarm_word;
            default: begin
              in_pair = 1'b0;
            end
          endcase
          if ((rd_func_i != 8'h03) && (rd_func_i != 8'h04)) begin
            // Writes and other functions are refused: map is read-only.
            nxt_state.rd_exc = 1'b1;
            nxt_state.rd_exc_code = 8'h01;
            nxt_state.rd_data = '0;
          end else if (rd_addr_i >= `LGR_MAP_END) begin
            nxt_state.rd_exc = 1'b1;
            nxt_state.rd_exc_code = `LGR_EXC_ADDR;
            nxt_state.rd_data = '0;
          end else if (in_pair) begin
            // High word at the even number, low word after it.
            nxt_state.rd_data = lo_half ? pair[15:0] : pair[31:16];
          end else if (rd_addr_i == `LGR_REG_VCF_ERR) begin
            nxt_state.rd_data = {12'h000, vcf_err_i};
          end else if (rd_addr_i == `LGR_REG_VOL_ERR) begin
            nxt_state.rd_data = {13'h0000, vol_err_i};
          end else if (rd_addr_i == `LGR_REG_CFG_ERR) begin
            nxt_state.rd_data = {6'h00, state_ff.cfg_err};
          end else begin
            // A reserved pair reads 8000H then 0000H, i.e. 80000000H.
            nxt_state.rd_data = (rd_addr_i[0] && rd_addr_i > 16'h000E) ?
              16'h0000 : `LGR_RSV_WORD;
          end
        end
      end
      lgr_pkg::LGR_ST_ANSWER: begin
        // One idle cycle between answers keeps each reply a clean pulse.
        nxt_state.st = lgr_pkg::LGR_ST_IDLE;
      end
      default: begin
        nxt_state.st = lgr_pkg::LGR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_valid_o = state_ff.rd_valid;
  assign rd_data_o = state_ff.rd_data;
  assign rd_exc_o = state_ff.rd_exc;
  assign rd_exc_code_o = state_ff.rd_exc_code;
  assign strap_table_sel_o = state_ff.strap_sel;
  assign avg_seconds_o = state_ff.avg_sec;
  assign cfg_err_o = state_ff.cfg_err;
  assign alarm_status_word_o = state_ff.alarm_word;

endmodule

// ===== lgr_regs_asserts.sv
module lgr_regs_chk (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_func_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic rd_valid_o,
  input wire logic [15:0] rd_data_o,
  input wire logic rd_exc_o,
  input wire logic [7:0] rd_exc_code_o,
  input wire logic cfg_vol_mode_i,
  input wire logic signed [31:0] tavg_meas_i,
  input wire logic signed [31:0] tavg_hi_lim_i,
  input wire logic signed [31:0] tavg_lo_lim_i,
  input wire logic magnet_missing_i,
  input wire logic [4:0] tsens_err_i,
  input wire logic tavg_err_i,
  input wire logic strap_table_sel_o,
  input wire logic [31:0] alarm_status_word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Outputs trail inputs by up to two cycles, so wait that out after reset.
  logic [1:0] up_ff;
  logic [1:0] nxt_up;
  always_comb nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
    if (!rstn_i) up_ff <= 2'h0;
    else up_ff <= nxt_up;

  // Answer timing, refusals and fixed answers.
  a_valid_pulse: assert property (rd_valid_o |=> !rd_valid_o)
    else $error("answer strobe longer than one cycle");
  a_req_answer: assert property (
    rd_req_i && !$past(rd_req_i) |=> rd_valid_o)
    else $error("request not answered next cycle");
  a_range_exc: assert property (
    rd_valid_o && $past(rd_addr_i) >= 16'h144D &&
    $past(rd_func_i) inside {8'h03, 8'h04} |->
    rd_exc_o && rd_exc_code_o == 8'h02)
    else $error("read past the map not refused");
  a_func_exc: assert property (
    rd_valid_o && !($past(rd_func_i) inside {8'h03, 8'h04}) |->
    rd_exc_o && rd_exc_code_o == 8'h01)
    else $error("bad function not refused");
  a_reserved_word: assert property (
    rd_valid_o && $past(rd_func_i) inside {8'h03, 8'h04} &&
    $past(rd_addr_i) inside {[16'h000F:16'h144C]} |-> !rd_exc_o &&
    rd_data_o == ((($past(rd_addr_i) & 16'h0001) != 16'h0000) ?
    16'h0000 : 16'h8000))
    else $error("reserved address answer wrong");
  a_alarm_hiword: assert property (
    rd_valid_o && !rd_exc_o && $past(rd_addr_i) == 16'h000A |->
    rd_data_o == 16'h0000)
    else $error("alarm high word not zero");
  a_status_bits: assert property (
    (up_ff == 2'h3 && $stable({tavg_err_i, tsens_err_i,
    magnet_missing_i})) [*3] |-> alarm_status_word_o[14:8] ==
    {tavg_err_i, tsens_err_i, magnet_missing_i})
    else $error("status bits do not follow inputs");
  a_tavg_alarm: assert property (
    (up_ff == 2'h3 && $stable({tavg_meas_i, tavg_hi_lim_i,
    tavg_lo_lim_i})) [*3] |-> alarm_status_word_o[7:6] ==
    {tavg_meas_i <= tavg_lo_lim_i, tavg_meas_i >= tavg_hi_lim_i})
    else $error("temperature alarms wrong");
  a_strap_mode: assert property (
    (up_ff == 2'h3 && $stable(cfg_vol_mode_i)) [*2] |->
    strap_table_sel_o == cfg_vol_mode_i)
    else $error("volume mode decode wrong");

  // Main scenarios seen at least once.
  c_exc: cover property (rd_valid_o && rd_exc_o);
  c_rsv: cover property (rd_valid_o && rd_data_o == 16'h8000);
  c_alarm: cover property (alarm_status_word_o[6]);
endmodule

// ===== lgr_master_model.sv
module lgr_master_model (
  input wire logic sys_clk_i,
  output logic rd_req_o,
  output logic [7:0] rd_func_o,
  output logic [15:0] rd_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle before the first read.
  initial begin
    rd_req_o = 1'b0;
    rd_func_o = 8'h03;
    rd_addr_o = 16'h0000;
  end

  // One read; hold2 keeps the strobe up one extra cycle on purpose.
  task automatic rd(input logic [7:0] fn, input logic [15:0] ad,
                    input bit hold2);
    @(posedge sys_clk_i);
    #1;
    rd_req_o = 1'b1;
    rd_func_o = fn;
    rd_addr_o = ad;
    @(posedge sys_clk_i);
    if (hold2) @(posedge sys_clk_i);
    #1;
    rd_req_o = 1'b0;
    // Released lines change, so a stale value can never pass as valid.
    rd_func_o = ~fn;
    rd_addr_o = ~ad;
  endtask
endmodule

// ===== level_gauge_register_map_test.sv
module level_gauge_register_map_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, rstn_i, rd_req_i, rd_valid_o, rd_exc_o, cfg_vol_mode_i;
  logic two_float_i, magnet_missing_i, tavg_err_i, strap_table_sel_o;
  logic [7:0] rd_func_i, rd_exc_code_o, cfg_avg_code_i, cfg_dev_addr_i;
  logic [15:0] rd_addr_i, rd_data_o;
  logic [2:0] cfg_method_i, vol_err_i;
  logic [3:0] cfg_temp_unit_i, cfg_dens_unit_i, cfg_vol_unit_i;
  logic [3:0] cfg_len_unit_i, cfg_mass_unit_i, vcf_err_i;
  logic [1:0] cfg_alarm_unit_i;
  logic [4:0] tsens_err_i;
  logic [5:0] avg_seconds_o;
  logic [9:0] cfg_err_o;
  logic [31:0] cfg_tec_i, gross_total_volume_i, gross_interface_volume_i;
  logic [31:0] working_capacity_i, volume_correction_factor_i;
  logic [31:0] alarm_status_word_o;
  logic signed [31:0] intf_meas_i, prod_meas_i, limit_meas_i, tavg_meas_i;
  logic signed [31:0] intf_hi_lim_i, intf_lo_lim_i, prod_hi_lim_i;
  logic signed [31:0] prod_lo_lim_i, limit_hi_lim_i, limit_lo_lim_i;
  logic signed [31:0] tavg_hi_lim_i, tavg_lo_lim_i;
  int failures, comparisons;
  logic [31:0] seed = 32'h0000_19ca;
  logic [31:0] expq [$];
  logic [31:0] tecs [4] = '{32'h0000_0A8B, 32'h0000_0A8C, 32'h0000_2454,
                           32'h0000_2455};
  logic [7:0] adrs [4] = '{8'h00, 8'h01, 8'hF7, 8'hF8};

  lgr_level_gauge_regs i_dut (.*);
  lgr_master_model i_mst (.sys_clk_i(sys_clk_i), .rd_req_o(rd_req_i),
    .rd_func_o(rd_func_i), .rd_addr_o(rd_addr_i));

  // Free-running system clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Each answer strobe retires the oldest expectation; extras are errors.
  // Sampled mid-cycle, where the registered answer has settled.
  always @(negedge sys_clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (expq.size() == 0) check({rd_exc_o, rd_data_o}, '1);
      else check({rd_exc_o, rd_exc_code_o, rd_data_o}, expq.pop_front());
    end
  end

  // Note the expected {code, data} and issue the read.
  task automatic rdx(input logic [7:0] fn, input logic [15:0] ad,
                     input logic [23:0] want);
    expq.push_back({7'h0, want[23:16] != 8'h00, want});
    i_mst.rd(fn, ad, 1'b0);
  endtask

  // Thresholds straddle the value so equality is hit often.
  task automatic pick(output logic signed [31:0] m, h, l);
    m = $signed(rnd()) >>> 2;
    h = m + 32'(rnd() % 3) - 32'h1;
    l = m + 32'(rnd() % 3) - 32'h1;
  endtask

  task automatic drive(input int i);
    cfg_method_i = 3'(rnd() % 7);
    cfg_tec_i = tecs[rnd() % 4];
    cfg_vol_mode_i = 1'(rnd());
    cfg_avg_code_i = 8'(rnd() % 66);
    cfg_temp_unit_i = 4'(rnd() % 3);
    cfg_dens_unit_i = 4'(rnd() % 10);
    cfg_vol_unit_i = 4'(rnd() % 8);
    cfg_len_unit_i = 4'(rnd() % 8);
    cfg_mass_unit_i = 4'(rnd() % 7);
    cfg_dev_addr_i = adrs[rnd() % 4];
    cfg_alarm_unit_i = 2'(rnd());
    two_float_i = 1'(rnd());
    pick(intf_meas_i, intf_hi_lim_i, intf_lo_lim_i);
    pick(prod_meas_i, prod_hi_lim_i, prod_lo_lim_i);
    pick(limit_meas_i, limit_hi_lim_i, limit_lo_lim_i);
    pick(tavg_meas_i, tavg_hi_lim_i, tavg_lo_lim_i);
    magnet_missing_i = 1'(rnd());
    tsens_err_i = 5'(rnd());
    tavg_err_i = 1'(rnd());
    vcf_err_i = 4'(i % 10);
    vol_err_i = 3'(i % 5);
    gross_interface_volume_i = rnd() % 524288;
    gross_total_volume_i = gross_interface_volume_i + rnd() % 524288;
    working_capacity_i = gross_total_volume_i + rnd() % 65536;
    volume_correction_factor_i = 9000 + rnd() % 2000;
  endtask

  // Random settings and measurements, then decode checks and a map sweep.
  task automatic one_pass(input int i);
    logic [31:0] aw;
    logic [31:0] v [6];
    logic [15:0] w [15];
    logic [63:0] p;
    logic [9:0] ce;
    logic [5:0] secs;
    @(posedge sys_clk_i);
    #1;
    drive(i);
    repeat (3) @(posedge sys_clk_i);
    #1;
    aw = 32'h0000_0000;
    aw[1:0] = {intf_meas_i <= intf_lo_lim_i, intf_meas_i >= intf_hi_lim_i};
    aw[3:2] = {prod_meas_i <= prod_lo_lim_i, prod_meas_i >= prod_hi_lim_i};
    aw[5:4] = {limit_meas_i <= limit_lo_lim_i,
               limit_meas_i >= limit_hi_lim_i};
    aw[7:6] = {tavg_meas_i <= tavg_lo_lim_i, tavg_meas_i >= tavg_hi_lim_i};
    if (cfg_alarm_unit_i < 2'h2) aw[5:0] = 6'h00;
    if (cfg_alarm_unit_i == 2'h2) aw[5:4] = 2'h0;
    aw[14:8] = {tavg_err_i, tsens_err_i, magnet_missing_i};
    check(alarm_status_word_o, aw);
    ce[0] = cfg_method_i == 3'h0 || cfg_method_i > 3'h5;
    ce[1] = cfg_method_i == 3'h3 && (cfg_tec_i < 32'h0000_0A8C ||
            cfg_tec_i > 32'h0000_2454);
    ce[2] = cfg_avg_code_i != 8'h00 && (cfg_avg_code_i % 5 != 0 ||
            cfg_avg_code_i > 8'h3C);
    secs = (ce[2] || cfg_avg_code_i == 8'h00) ? 6'h01 : 6'(cfg_avg_code_i);
    ce[3] = cfg_temp_unit_i > 4'h1;
    ce[4] = cfg_dens_unit_i > 4'h8;
    ce[5] = cfg_vol_unit_i > 4'h6;
    ce[6] = cfg_len_unit_i > 4'h6;
    ce[7] = cfg_mass_unit_i > 4'h5;
    ce[8] = cfg_dev_addr_i == 8'h00 || cfg_dev_addr_i > 8'hF7;
    ce[9] = cfg_alarm_unit_i < 2'h2;
    check(cfg_err_o, ce);
    check(avg_seconds_o, secs);
    check(strap_table_sel_o, cfg_vol_mode_i);
    v[0] = two_float_i ? gross_total_volume_i - gross_interface_volume_i
                       : gross_total_volume_i;
    v[1] = gross_interface_volume_i;
    v[2] = gross_total_volume_i;
    v[3] = working_capacity_i - gross_total_volume_i;
    p = 64'(v[0]) * 64'(volume_correction_factor_i) / 10000;
    v[4] = p[31:0];
    v[5] = aw;
    for (int k = 0; k < 6; k++) begin
      w[2 * k] = v[k][31:16];
      w[2 * k + 1] = v[k][15:0];
    end
    w[12] = {12'h000, vcf_err_i};
    w[13] = {13'h0000, vol_err_i};
    w[14] = {6'h00, ce};
    for (int k = 0; k < 15; k++) begin
      rdx((k % 2) ? 8'h04 : 8'h03, 16'(k), {8'h00, w[k]});
    end
  endtask

  // Reserved places, the map end, a bad function and a held request.
  task automatic edges();
    rdx(8'h03, 16'h000F, 24'h00_0000);
    rdx(8'h04, 16'h0010, 24'h00_8000);
    rdx(8'h03, 16'h0011, 24'h00_0000);
    rdx(8'h03, 16'h144C, 24'h00_8000);
    rdx(8'h04, 16'h144D, 24'h02_0000);
    rdx(8'h03, 16'hFFFF, 24'h02_0000);
    rdx(8'h06, 16'h0000, 24'h01_0000);
    expq.push_back(32'h0000_8000);
    i_mst.rd(8'h04, 16'h0010, 1'b1);
    repeat (3) @(posedge sys_clk_i);
  endtask

  // Main sequence.
  initial begin
    failures = 0;
    comparisons = 0;
    rstn_i = 1'b0;
    drive(0);
    repeat (12) @(posedge sys_clk_i);
    #1;
    check(rd_valid_o, 1'b0);
    check(alarm_status_word_o, 32'h0000_0000);
    rstn_i = 1'b1;
    for (int i = 0; i < 40; i++) one_pass(i);
    $display("test settings_and_map done");
    edges();
    $display("test reserved_and_refusals done");
    for (int n = 0; n < 20 && expq.size() != 0; n++) @(posedge sys_clk_i);
    check(expq.size(), 0);
    print_verdict();
  end

  // A hang is cut short well past the expected run length.
  initial begin
    #(100 * 8000);
    failures++;
    print_verdict();
  end
endmodule

bind lgr_level_gauge_regs lgr_regs_chk i_chk (.*);
